// ==== common/tx_pin_mux_pkg.sv ====
// constants and types shared by the transmit pin role multiplexer
package tx_pin_mux_pkg;
  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_ADD_BYTE = 5'h04;
  localparam logic [4:0] ADDR_PKT_BYTE = 5'h08;
  localparam logic [4:0] ADDR_SERIAL = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // ------------------------------------------------------------------
  // control field positions and reset value
  // ------------------------------------------------------------------
  localparam int CTRL_ADD_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_HI = 2;
  localparam int CTRL_SW_ALARM = 3;
  localparam int CTRL_SW_ALARM_VAL = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // ------------------------------------------------------------------
  // counts (cycles of aclk, bits of payload clock)
  // ------------------------------------------------------------------
  localparam int PKT_HALF_DEF = 4;
  localparam int FRAME_BITS_DEF = 1024;
  localparam int OH_BITS_DEF = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // operating modes while the add bus is disabled
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PACKET = 2'b00,
    MODE_CLEAR = 2'b01,
    MODE_MAPPER = 2'b10,
    MODE_FRAMER = 2'b11
  } role_mode_e;
endpackage

// ==== rtl/tx_channel_input_pin_mux.sv ====
// transmit data pins 4..7 role multiplexer with AXI4-Lite control
`timescale 1ns/1ns
module tx_channel_input_pin_mux #(
  parameter int PKT_HALF = tx_pin_mux_pkg::PKT_HALF_DEF,
  parameter int FRAME_BITS = tx_pin_mux_pkg::FRAME_BITS_DEF,
  parameter int OH_BITS = tx_pin_mux_pkg::OH_BITS_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // shared data lines (0..3 belong to neighbouring pins)
  input wire logic [7:0] pin_in,
  output logic overhead_slot_indicator,
  output logic overhead_slot_indicator_oe,
  output logic frame_boundary_pulse,
  output logic frame_boundary_pulse_oe,
  // clocks from and to the system side
  input wire logic add_bus_clock_ch1,
  input wire logic payload_in_clock,
  output logic packet_tx_byte_clock,
  output logic packet_tx_byte_clock_oe,
  // captured data toward the channel
  output logic [7:0] add_bus_data_ch1,
  output logic add_byte_valid,
  output logic [7:0] packet_tx_byte,
  output logic packet_byte_valid,
  output logic payload_serial_in,
  output logic payload_bit_valid,
  output logic alarm_pattern_request
);
  import tx_pin_mux_pkg::*;

  // ------------------------------------------------------------------
  // input synchronisers and edge detection
  // ------------------------------------------------------------------
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  logic add_clk_d_r;
  logic pay_clk_d_r;
  logic [4:0] ctrl_r;

  // two stages for the pins and both outside clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
      add_clk_d_r <= 1'b0;
      pay_clk_d_r <= 1'b0;
    end else begin
      sync1_r <= {payload_in_clock, add_bus_clock_ch1, pin_in};
      sync2_r <= sync1_r;
      add_clk_d_r <= sync2_r[8];
      pay_clk_d_r <= sync2_r[9];
    end
  end

  wire [7:0] line_s = sync2_r[7:0];
  wire add_fall = add_clk_d_r & ~sync2_r[8];
  wire pay_rise = ~pay_clk_d_r & sync2_r[9];
  wire add_en = ctrl_r[CTRL_ADD_EN];
  wire [1:0] mode = ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO];

  // role decode: add bus first, then the mode
  wire pkt_mode = ~add_en & (mode == MODE_PACKET);
  wire clear_mode = ~add_en & (mode == MODE_CLEAR);
  wire framer_any = ~add_en & (mode == MODE_CLEAR | mode == MODE_FRAMER);

  // ------------------------------------------------------------------
  // add bus capture
  // ------------------------------------------------------------------
  logic [7:0] add_byte_r;
  logic add_vld_r;

  // whole byte latched at the add clock falling edge, line 7 is msb
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      add_byte_r <= 8'h00;
      add_vld_r <= 1'b0;
    end else begin
      add_vld_r <= add_en & add_fall;
      if (add_en && add_fall) begin
        add_byte_r <= line_s;
      end
    end
  end

  add_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (add_en && add_fall) |=> (add_vld_r && add_byte_r == $past(line_s)))
    else $error("add byte not captured at add clock fall");

  // ------------------------------------------------------------------
  // packet byte clock and capture
  // ------------------------------------------------------------------
  logic [15:0] div_cnt_r;
  logic pkt_clk_r;
  logic [1:0] rise_d_r;
  logic [7:0] pkt_byte_r;
  logic pkt_vld_r;

  wire div_tick = (div_cnt_r == 16'(PKT_HALF - 1));
  wire pkt_rise = pkt_mode & div_tick & ~pkt_clk_r;

  // divider toggles the byte clock only in packet mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !pkt_mode) begin
      div_cnt_r <= 16'h0000;
      pkt_clk_r <= 1'b0;
    end else begin
      div_cnt_r <= div_tick ? 16'h0000 : div_cnt_r + 16'h0001;
      if (div_tick) begin
        pkt_clk_r <= ~pkt_clk_r;
      end
    end
  end

  // synced lines reach the capture two cycles after the rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_d_r <= 2'h0;
      pkt_byte_r <= 8'h00;
      pkt_vld_r <= 1'b0;
    end else begin
      rise_d_r <= {rise_d_r[0], pkt_rise};
      pkt_vld_r <= rise_d_r[1] & pkt_mode;
      if (rise_d_r[1] && pkt_mode) begin
        pkt_byte_r <= line_s;
      end
    end
  end

  pkt_clk_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pkt_mode |=> !pkt_clk_r)
    else $error("byte clock runs outside packet mode");

  sequence pkt_mode_hold_s;
    pkt_mode[*3];
  endsequence

  pkt_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(pkt_clk_r) ##0 pkt_mode_hold_s) |->
      (pkt_vld_r && pkt_byte_r == $past(pin_in, 3)))
    else $error("packet byte not taken at byte clock rise");

  // ------------------------------------------------------------------
  // serial payload and frame boundary
  // ------------------------------------------------------------------
  logic [31:0] ser_shift_r;
  logic ser_vld_r;
  logic [15:0] bit_cnt_r;
  logic fbp_r;
  logic oh_r;

  wire frame_wrap = (bit_cnt_r == 16'(FRAME_BITS - 1));

  // line 6 sampled at each payload clock rise; boundary one period wide
  always_ff @(posedge aclk) begin
    if (!aresetn || !clear_mode) begin
      ser_shift_r <= 32'h0000_0000;
      ser_vld_r <= 1'b0;
      bit_cnt_r <= 16'h0000;
      fbp_r <= 1'b0;
      oh_r <= 1'b0;
    end else begin
      ser_vld_r <= pay_rise;
      if (pay_rise) begin
        ser_shift_r <= {ser_shift_r[30:0], line_s[6]};
        bit_cnt_r <= frame_wrap ? 16'h0000 : bit_cnt_r + 16'h0001;
        fbp_r <= frame_wrap;
        oh_r <= frame_wrap | (bit_cnt_r < 16'(OH_BITS - 1));
      end
    end
  end

  ser_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear_mode && pay_rise) ##1 clear_mode |->
      (ser_vld_r && ser_shift_r[0] == $past(line_s[6])))
    else $error("payload bit not sampled at payload clock rise");

  boundary_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fbp_r) |-> $past(pay_rise && frame_wrap))
    else $error("frame boundary rose off a payload clock edge");

  boundary_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fbp_r && pay_rise && FRAME_BITS > 1) |=> !fbp_r)
    else $error("frame boundary wider than one period");

  // ------------------------------------------------------------------
  // alarm pattern request
  // ------------------------------------------------------------------
  logic alarm_r;
  wire sw_alarm = ctrl_r[CTRL_SW_ALARM];
  // pin 7 ignored when software owns the alarm
  wire alarm_nxt = sw_alarm ? ctrl_r[CTRL_SW_ALARM_VAL] : line_s[7];

  // frame generator request follows the pin only in framer modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= framer_any & alarm_nxt;
    end
  end

  alarm_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (framer_any && !sw_alarm) |=> (alarm_r == $past(line_s[7])))
    else $error("alarm request does not follow its pin");

  alarm_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !framer_any |=> !alarm_r)
    else $error("alarm request active outside framer modes");

  // ------------------------------------------------------------------
  // pin drive: only the selected output role drives
  // ------------------------------------------------------------------
  assign frame_boundary_pulse = fbp_r;
  assign frame_boundary_pulse_oe = clear_mode;
  assign overhead_slot_indicator = oh_r;
  assign overhead_slot_indicator_oe = clear_mode;
  assign packet_tx_byte_clock = pkt_clk_r;
  assign packet_tx_byte_clock_oe = pkt_mode;
  assign add_bus_data_ch1 = add_byte_r;
  assign add_byte_valid = add_vld_r;
  assign packet_tx_byte = pkt_byte_r;
  assign packet_byte_valid = pkt_vld_r;
  assign payload_serial_in = ser_shift_r[0];
  assign payload_bit_valid = ser_vld_r;
  assign alarm_pattern_request = alarm_r;

  release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    add_en |-> (!frame_boundary_pulse_oe && !overhead_slot_indicator_oe
      && !packet_tx_byte_clock_oe))
    else $error("output role driven while add bus enabled");

  // ------------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [4:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign awready = ~aw_held_r & ~bvalid_r;
  assign wready = ~w_held_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire aw_have = aw_held_r | aw_take;
  wire w_have = w_held_r | w_take;
  wire do_write = aw_have & w_have & ~bvalid_r;
  wire [4:0] wr_addr = aw_held_r ? aw_addr_r : awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : wdata;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : wstrb;
  wire wr_ctrl = do_write & (wr_addr == ADDR_CTRL);
  wire wr_ok = (wr_addr == ADDR_CTRL) | (wr_addr == ADDR_ADD_BYTE)
    | (wr_addr == ADDR_PKT_BYTE) | (wr_addr == ADDR_SERIAL)
    | (wr_addr == ADDR_STATUS);
  wire ar_take = arvalid & arready;
  wire [31:0] status_w = {26'h0, alarm_r, fbp_r, pkt_clk_r, mode, add_en};
  wire wr_ok_rd = (araddr == ADDR_CTRL) | (araddr == ADDR_ADD_BYTE)
    | (araddr == ADDR_PKT_BYTE) | (araddr == ADDR_SERIAL)
    | (araddr == ADDR_STATUS);
  wire rd_ok = wr_ok_rd;
  wire [31:0] rd_mux =
    (araddr == ADDR_CTRL) ? {27'h0, ctrl_r} :
    (araddr == ADDR_ADD_BYTE) ? {24'h0, add_byte_r} :
    (araddr == ADDR_PKT_BYTE) ? {24'h0, pkt_byte_r} :
    (araddr == ADDR_SERIAL) ? ser_shift_r :
    (araddr == ADDR_STATUS) ? status_w : 32'h0000_0000;

  // address and data may arrive in either order; write once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= awaddr;
      end
      if (w_take) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      aw_held_r <= aw_have & ~do_write;
      w_held_r <= w_have & ~do_write;
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // control register, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl && wr_strb[0]) begin
      ctrl_r <= wr_data[4:0];
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_r && !bready) |=> (bvalid_r && $stable(bresp_r)))
    else $error("write response dropped before bready");

endmodule // tx_channel_input_pin_mux

// ==== dv/system_side_model.sv ====
// system side terminal model driving the shared transmit lines
`timescale 1ns/1ns
module system_side_model (
  // clocks
  input wire logic aclk,
  input wire logic packet_tx_byte_clock,
  // lines toward the device
  output logic [7:0] pin_in,
  output logic add_bus_clock_ch1,
  output logic payload_in_clock
);
  logic [7:0] next_byte;
  logic pkt_role;
  logic clk_d;
  // idle lines low, outside clocks stand still
  initial begin
    pin_in = 8'h00;
    next_byte = 8'h00;
    pkt_role = 1'b1;
    clk_d = 1'b0;
    add_bus_clock_ch1 = 1'b0;
    payload_in_clock = 1'b0;
  end
  // lines follow next_byte; in the packet role only after a clock rise
  always @(posedge aclk) begin
    clk_d <= packet_tx_byte_clock;
    if (!pkt_role || (packet_tx_byte_clock && !clk_d)) begin
      pin_in <= next_byte;
    end
  end
  // static lines or the next packet byte
  task automatic set_lines(input logic [7:0] l, input logic pkt);
    pkt_role <= pkt;
    next_byte <= l;
  endtask
  // one add byte, msb on line 7, taken at the clock fall
  task automatic send_add(input logic [7:0] b);
    next_byte <= b;
    repeat (4) @(posedge aclk);
    add_bus_clock_ch1 <= 1'b1;
    repeat (4) @(posedge aclk);
    add_bus_clock_ch1 <= 1'b0;
    repeat (4) @(posedge aclk);
    next_byte <= ~b;
  endtask
  // serial payload on line 6, msb first
  task automatic send_bits(input int n, input logic [63:0] bits);
    int i;
    for (i = n - 1; i >= 0; i--) begin
      next_byte <= {1'b0, bits[i], 6'h00};
      repeat (4) @(posedge aclk);
      payload_in_clock <= 1'b1;
      repeat (4) @(posedge aclk);
      payload_in_clock <= 1'b0;
    end
    next_byte <= {1'b0, ~bits[0], 6'h00};
  endtask
endmodule // system_side_model

// ==== dv/test_tx_channel_input_pin_mux.sv ====
// self-checking bench for the transmit pin role multiplexer
`timescale 1ns/1ns
module test_tx_channel_input_pin_mux;
  import tx_pin_mux_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_in, add_data, pkt_byte;
  logic fbp, fbp_oe, add_clk, pay_clk, pkt_clk, pkt_oe, alarm;
  logic pkt_valid, oh, oh_oe, add_vld, bit_vld, ser_bit;
  int num_errors, samples_checked, fb_pulses, fb_high;
  int oh_high, add_pulses, bit_pulses;

  tx_channel_input_pin_mux #(.PKT_HALF(2), .FRAME_BITS(8), .OH_BITS(2))
  u_tx_channel_input_pin_mux (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .overhead_slot_indicator(oh),
    .overhead_slot_indicator_oe(oh_oe), .frame_boundary_pulse(fbp),
    .frame_boundary_pulse_oe(fbp_oe), .add_bus_clock_ch1(add_clk),
    .payload_in_clock(pay_clk), .packet_tx_byte_clock(pkt_clk),
    .packet_tx_byte_clock_oe(pkt_oe), .add_bus_data_ch1(add_data),
    .add_byte_valid(add_vld), .packet_tx_byte(pkt_byte),
    .packet_byte_valid(pkt_valid), .payload_serial_in(ser_bit),
    .payload_bit_valid(bit_vld), .alarm_pattern_request(alarm));

  system_side_model u_system_side_model (
    .aclk(aclk), .packet_tx_byte_clock(pkt_clk), .pin_in(pin_in),
    .add_bus_clock_ch1(add_clk), .payload_in_clock(pay_clk));

  // compare and count
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // axi4-lite write, both channels offered together; bready stays high
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    check("bresp", 32'(er), 32'(bresp));
  endtask
  // axi4-lite read with masked compare; rready stays high
  task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                    input logic [31:0] m, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    check("rdata", ed & m, rdata & m);
    check("rresp", 32'(er), 32'(rresp));
  endtask
  // skip past any byte already in flight
  task automatic wait_pkt();
    int i;
    for (i = 0; i < 3; i++) begin
      do @(posedge aclk); while (pkt_valid !== 1'b1);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // frame boundary pulses and their width, other strobes counted too
  always @(posedge aclk) begin
    if (fbp === 1'b1) fb_high++;
    if (oh === 1'b1) oh_high++;
    if (add_vld === 1'b1) add_pulses++;
    if (bit_vld === 1'b1) bit_pulses++;
    if ($rose(fbp)) fb_pulses++;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    test_done();
  end
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    check("fbp_oe", 32'h0, 32'(fbp_oe));
    u_system_side_model.set_lines(8'hA5, 1'b1);
    wait_pkt();
    check("pkt_byte", 32'hA5, 32'(pkt_byte));
    u_system_side_model.set_lines(8'h5A, 1'b1);
    wait_pkt();
    check("pkt_byte", 32'h5A, 32'(pkt_byte));
    check("pkt_oe", 32'h1, 32'(pkt_oe));
    rd(ADDR_PKT_BYTE, 32'h5A, 32'hFFFFFFFF, RESP_OKAY);
    rd(5'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(5'h14, 32'h1, RESP_SLVERR);
    wr(ADDR_ADD_BYTE, 32'hFF, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    u_system_side_model.set_lines(8'h00, 1'b0);
    wr(ADDR_CTRL, 32'h01, RESP_OKAY);
    check("pkt_oe", 32'h0, 32'(pkt_oe));
    u_system_side_model.send_add(8'h81);
    repeat (6) @(posedge aclk);
    check("add_data", 32'h81, 32'(add_data));
    u_system_side_model.send_add(8'h6C);
    repeat (6) @(posedge aclk);
    check("add_data", 32'h6C, 32'(add_data));
    check("add_pulses", 32'd2, 32'(add_pulses));
    rd(ADDR_ADD_BYTE, 32'h6C, 32'hFFFFFFFF, RESP_OKAY);
    wr(ADDR_CTRL, 32'h02, RESP_OKAY);
    check("fbp_oe", 32'h1, 32'(fbp_oe));
    check("oh_oe", 32'h1, 32'(oh_oe));
    fb_pulses = 0;
    fb_high = 0;
    oh_high = 0;
    u_system_side_model.send_bits(36, 64'h9C3F09E5B);
    repeat (10) @(posedge aclk);
    check("fb_pulses", 32'd4, 32'(fb_pulses));
    check("fb_high", 32'd32, 32'(fb_high));
    check("oh_high", 32'd72, 32'(oh_high));
    check("bit_pulses", 32'd36, 32'(bit_pulses));
    check("ser_bit", 32'h1, 32'(ser_bit));
    rd(ADDR_SERIAL, 32'hC3F09E5B, 32'hFFFFFFFF, RESP_OKAY);
    wr(ADDR_CTRL, 32'h06, RESP_OKAY);
    u_system_side_model.set_lines(8'h80, 1'b0);
    repeat (6) @(posedge aclk);
    check("alarm", 32'h1, 32'(alarm));
    rd(ADDR_STATUS, 32'h06, 32'h7, RESP_OKAY);
    u_system_side_model.set_lines(8'h00, 1'b0);
    repeat (6) @(posedge aclk);
    check("alarm", 32'h0, 32'(alarm));
    wr(ADDR_CTRL, 32'h1E, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check("alarm", 32'h1, 32'(alarm));
    wr(ADDR_CTRL, 32'h0E, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check("alarm", 32'h0, 32'(alarm));
    wr(ADDR_CTRL, 32'h04, RESP_OKAY);
    check("pkt_oe", 32'h0, 32'(pkt_oe));
    check("fbp_oe", 32'h0, 32'(fbp_oe));
    check("oh_oe", 32'h0, 32'(oh_oe));
    test_done();
  end
endmodule // test_tx_channel_input_pin_mux
